/* hw/mcb_regs.svh */
/*
  Constants for the motion command block decoder: word indices, bit
  positions, command codes, ranges. Assumes plain inclusion by both ends.
*/
`ifndef MCB_REGS_SVH
`define MCB_REGS_SVH
`define MCB_NUM_WORDS 10
`define MCB_W_CMD0 0
`define MCB_W_CMD1 1
`define MCB_W_POS_HI 2
`define MCB_W_POS_LO 3
`define MCB_W_SPD_HI 4
`define MCB_W_SPD_LO 5
`define MCB_W_ACC 6
`define MCB_W_DEC 7
`define MCB_W_CUR 8
`define MCB_W_JERK 9
`define MCB_C0_ABS 0
`define MCB_C0_REL 1
`define MCB_C0_HOLD 2
`define MCB_C0_RESUME 3
`define MCB_C0_ESTOP 4
`define MCB_C0_PROG_SEG 12
`define MCB_C0_ENC_PRESET 14
`define MCB_C1_NV_STORE 5
`define MCB_C1_BLEND_CCW 4
`define MCB_C1_CUR_OVR 1
`define MCB_C1_RSVD_MASK 16'h000D
`define MCB_CODE_ABS 16'h0001
`define MCB_CODE_REL 16'h0002
`define MCB_CODE_HOLD 16'h0004
`define MCB_CODE_RESUME 16'h0008
`define MCB_CODE_ESTOP 16'h0010
`define MCB_POS_MIN 32'hFF800000
`define MCB_POS_MAX 32'h007FFFFF
`define MCB_SPD_MAX 32'h002DC6BF
`define MCB_RAMP_MIN 16'h0001
`define MCB_RAMP_MAX 16'h1388
`define MCB_CUR_MAX 16'h0022
`define MCB_ACK_BIT 13
`endif

/* hw/mcb_pkg.sv */
/*
  Types shared by both ends of the command block link.
  Assumes mcb_regs.svh supplies the numbers.
*/
`include "mcb_regs.svh"
package mcb_pkg;
  typedef logic [15:0] mcb_word_t;
  typedef enum logic [2:0] {MCB_OP_NONE, MCB_OP_ABS, MCB_OP_REL, MCB_OP_HOLD,
    MCB_OP_RESUME, MCB_OP_ESTOP} mcb_op_e;
  typedef enum {MCB_FL_IDLE, MCB_FL_WAIT, MCB_FL_LOCKED} mcb_flash_e;
endpackage

/* hw/mcb_if.sv */
/*
  Cyclic output block from controller to indexer, plus the status
  answer. Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
`include "mcb_regs.svh"
interface mcb_if;
  mcb_pkg::mcb_word_t words [`MCB_NUM_WORDS];
  logic [15:0] status1;
  modport ctrl (output words, input status1);
  modport dev (input words, output status1);
endinterface

/* hw/mcb_ctrl.sv */
/*
  Controller end: holds the ten output words, accepts word writes from
  the user, clears reserved bits and passes the store flag through as written.
  Assumes user writes are synchronous to i_ref_clk.
*/
`timescale 1ns/1ns
`include "mcb_regs.svh"
module mcb_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_wr,
  input wire logic [3:0] i_idx,
  input wire logic [15:0] i_data,
  output logic [15:0] o_status1,
  mcb_if.ctrl bus
);
  typedef struct packed {
    logic [`MCB_NUM_WORDS-1:0][15:0] w;
    logic [15:0] st;
  } mcb_ctrl_s;
  mcb_ctrl_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.st = bus.status1;
    if (i_wr && i_idx < 4'(`MCB_NUM_WORDS)) begin
      s_d.w[i_idx] = i_data;
    end
    // reserved bits forced low whatever the user writes
    s_d.w[`MCB_W_CMD1] = s_d.w[`MCB_W_CMD1] & ~`MCB_C1_RSVD_MASK;
    // store flag kept as user wrote it across the programming fall
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  for (genvar k = 0; k < `MCB_NUM_WORDS; k++) begin : g_w
    assign bus.words[k] = s_q.w[k];
  end
  assign o_status1 = s_q.st;
endmodule

/* hw/mcb_dev.sv */
/*
  Device end: decodes the ten-word command block on rising command bits
  and presents the decoded move. Assumes the block words are stable in
  the cycle a command bit rises; flash write itself is outside.
*/
// Function
// - controller holds store flag during programming fall
// - flash done: indicator green ok, red fail
// - after flash write, lock until power cycle
// - store with encoder preset; ack on success
// - blend direction: zero clockwise, one ccw
// - controller keeps reserved command bits zero
// - override flag selects word eight current
// - current update standalone or with move
// - code one absolute, signed 24-bit target
// - code two relative, signed 24-bit offset
// - controller keeps speed and ramps in range; mcb_ctrl passes them unchecked, o_range_err flags them
// - current 0..34, ignored without override
// - code four hold, other words ignored
// - resume keeps old target, new profile
// - code sixteen immediate stop, words ignored
// - unused words ignored whatever they hold
// - command bits act on rising edge
// - hold decelerates to start speed, resumable
`timescale 1ns/1ns
`include "mcb_regs.svh"
module mcb_dev (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [15:0] i_cfg_current,
  input wire logic i_flash_done,
  input wire logic i_flash_ok,
  input wire logic i_enc_store_ok,
  input wire logic i_blend_start,
  input wire logic i_at_start_speed,
  output logic o_cmd_valid,
  output mcb_pkg::mcb_op_e o_op,
  output logic [31:0] o_target,
  output logic [31:0] o_speed,
  output logic [15:0] o_accel,
  output logic [15:0] o_decel,
  output logic [15:0] o_jerk,
  output logic [15:0] o_current,
  output logic o_cur_valid,
  output logic o_range_err,
  output logic o_blend_ccw,
  output logic o_seg_store,
  output logic o_enc_store,
  output logic o_led_green,
  output logic o_led_red,
  output logic o_locked,
  output logic o_held,
  output logic o_stop_ramp,
  mcb_if.dev bus
);
  typedef struct packed {
    logic [15:0] c0_prev;
    logic cmd_valid;
    mcb_pkg::mcb_op_e op;
    logic [31:0] target;
    logic [31:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] jerk;
    logic [15:0] current;
    logic cur_valid;
    logic range_err;
    logic blend_ccw;
    logic seg_store;
    logic enc_store;
    logic ack;
    logic green;
    logic red;
    mcb_pkg::mcb_flash_e fl;
    logic held;
    logic stop_ramp;
  } mcb_dev_s;
  mcb_dev_s s_q, s_d;

  function automatic logic [31:0] join32(input logic [15:0] hi, input logic [15:0] lo);
    join32 = {hi, lo};
  endfunction

  function automatic logic pos_ok(input logic [31:0] v);
    pos_ok = ($signed(v) >= $signed(`MCB_POS_MIN)) && ($signed(v) <= $signed(`MCB_POS_MAX));
  endfunction

  logic [15:0] c0, c1, rise;
  logic [31:0] pos;
  assign c0 = bus.words[`MCB_W_CMD0];
  assign c1 = bus.words[`MCB_W_CMD1];
  assign rise = c0 & ~s_q.c0_prev;
  assign pos = join32(bus.words[`MCB_W_POS_HI], bus.words[`MCB_W_POS_LO]);

  always_comb begin
    s_d = s_q;
    s_d.c0_prev = c0;
    s_d.cmd_valid = 1'b0;
    s_d.cur_valid = 1'b0;
    s_d.seg_store = 1'b0;
    s_d.enc_store = 1'b0;
    // direction latched only when a blend starts, later edits of cmd1 do not steer it
    if (s_q.fl == mcb_pkg::MCB_FL_LOCKED) begin
      // no operation accepted until reset by power cycle
    end else if (s_q.fl == mcb_pkg::MCB_FL_WAIT) begin
      if (i_flash_done) begin
        s_d.fl = mcb_pkg::MCB_FL_LOCKED;
        s_d.green = i_flash_ok;
        s_d.red = !i_flash_ok;
      end
    end else begin
      // segment store on programming fall with flag set
      if (!c0[`MCB_C0_PROG_SEG] && s_q.c0_prev[`MCB_C0_PROG_SEG] && c1[`MCB_C1_NV_STORE]) begin
        s_d.seg_store = 1'b1;
        s_d.fl = mcb_pkg::MCB_FL_WAIT;
      end
      if (rise[`MCB_C0_ENC_PRESET] && c1[`MCB_C1_NV_STORE]) begin
        s_d.enc_store = 1'b1;
        s_d.ack = 1'b0;
      end
      if (i_enc_store_ok) begin
        s_d.ack = 1'b1;
      end
      if (rise[`MCB_C0_ESTOP]) begin
        s_d.op = mcb_pkg::MCB_OP_ESTOP; // other words untouched
        s_d.cmd_valid = 1'b1;
        s_d.held = 1'b0;
        s_d.stop_ramp = 1'b0;
      end else if (rise[`MCB_C0_HOLD]) begin
        s_d.op = mcb_pkg::MCB_OP_HOLD;
        s_d.cmd_valid = 1'b1;
        s_d.stop_ramp = 1'b1;
      end else if (rise[`MCB_C0_ABS] || rise[`MCB_C0_REL] || rise[`MCB_C0_RESUME]) begin
        s_d.cmd_valid = 1'b1;
        s_d.speed = join32(bus.words[`MCB_W_SPD_HI], bus.words[`MCB_W_SPD_LO]);
        s_d.accel = bus.words[`MCB_W_ACC];
        s_d.decel = bus.words[`MCB_W_DEC];
        s_d.jerk = bus.words[`MCB_W_JERK];
        s_d.held = 1'b0;
        s_d.stop_ramp = 1'b0;
        if (rise[`MCB_C0_ABS]) begin
          s_d.op = mcb_pkg::MCB_OP_ABS;
          s_d.target = pos;
        end else if (rise[`MCB_C0_REL]) begin
          s_d.op = mcb_pkg::MCB_OP_REL;
          s_d.target = pos;
        end else begin
          s_d.op = mcb_pkg::MCB_OP_RESUME; // target kept
        end
        // flag the profile if the controller left range
        s_d.range_err = (!rise[`MCB_C0_RESUME] && !pos_ok(pos))
          || s_d.speed > `MCB_SPD_MAX
          || s_d.accel < `MCB_RAMP_MIN || s_d.accel > `MCB_RAMP_MAX
          || s_d.decel < `MCB_RAMP_MIN || s_d.decel > `MCB_RAMP_MAX
          || s_d.jerk > `MCB_RAMP_MAX;
      end
      // current taken with a move, or alone while override is set and word eight differs from the current
      if ((s_d.cmd_valid && s_d.op != mcb_pkg::MCB_OP_HOLD
           && s_d.op != mcb_pkg::MCB_OP_ESTOP) || (rise == 16'h0000 && c1[`MCB_C1_CUR_OVR]
           && bus.words[`MCB_W_CUR] != s_q.current)) begin
        s_d.cur_valid = 1'b1;
        if (c1[`MCB_C1_CUR_OVR] && bus.words[`MCB_W_CUR] <= `MCB_CUR_MAX) begin
          s_d.current = bus.words[`MCB_W_CUR];
        end else begin
          s_d.current = i_cfg_current;
        end
      end
      if (s_q.stop_ramp && i_at_start_speed) begin
        s_d.stop_ramp = 1'b0;
        s_d.held = 1'b1;
      end
      if (i_blend_start) begin
        s_d.blend_ccw = c1[`MCB_C1_BLEND_CCW];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.status1 = {2'b00, s_q.ack, 13'h0000};
  assign o_cmd_valid = s_q.cmd_valid;
  assign o_op = s_q.op;
  assign o_target = s_q.target;
  assign o_speed = s_q.speed;
  assign o_accel = s_q.accel;
  assign o_decel = s_q.decel;
  assign o_jerk = s_q.jerk;
  assign o_current = s_q.current;
  assign o_cur_valid = s_q.cur_valid;
  assign o_range_err = s_q.range_err;
  assign o_blend_ccw = s_q.blend_ccw;
  assign o_seg_store = s_q.seg_store;
  assign o_enc_store = s_q.enc_store;
  assign o_led_green = s_q.green;
  assign o_led_red = s_q.red;
  assign o_locked = (s_q.fl == mcb_pkg::MCB_FL_LOCKED);
  assign o_held = s_q.held;
  assign o_stop_ramp = s_q.stop_ramp;
endmodule

/* dv/mcb_monitor.sv */
/* Checker on the command words and the decoded device outputs.
   Assumes one clock; tb instantiates it beside the link. */
`timescale 1ns/1ns
module mcb_monitor (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input mcb_pkg::mcb_word_t words [10],
  input wire logic [15:0] i_cfg_current,
  input wire logic o_cmd_valid,
  input mcb_pkg::mcb_op_e o_op,
  input wire logic [31:0] o_target,
  input wire logic [15:0] o_current,
  input wire logic o_locked
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // rise with none of the command bits in m set
  sequence s_rise(int b, logic [4:0] m);
    $rose(words[0][b]) && (words[0][4:0] & m) == 5'h00 && !o_locked;
  endsequence
  property p_rsvd;
    (words[1] & 16'h000D) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_abs;
    s_rise(0, 5'h1E) |=> o_cmd_valid && o_op == mcb_pkg::MCB_OP_ABS;
  endproperty
  a_abs: assert property (p_abs) else $error("abs missed");
  property p_rel;
    s_rise(1, 5'h1D) |=> o_cmd_valid && o_op == mcb_pkg::MCB_OP_REL;
  endproperty
  a_rel: assert property (p_rel) else $error("rel missed");
  property p_hold;
    s_rise(2, 5'h10) |=> o_cmd_valid && o_op == mcb_pkg::MCB_OP_HOLD && $stable(o_target);
  endproperty
  a_hold: assert property (p_hold) else $error("hold missed");
  property p_estop;
    s_rise(4, 5'h00) |=> o_cmd_valid && o_op == mcb_pkg::MCB_OP_ESTOP && $stable(o_target);
  endproperty
  a_estop: assert property (p_estop) else $error("stop missed");
  property p_tgt;
    o_cmd_valid && o_op == mcb_pkg::MCB_OP_ABS |-> o_target == {$past(words[2]), $past(words[3])};
  endproperty
  a_tgt: assert property (p_tgt) else $error("target order");
  property p_cur;
    o_cmd_valid && o_op == mcb_pkg::MCB_OP_REL |-> o_current ==
      ($past(words[1][1]) && $past(words[8]) <= 16'h0022 ? $past(words[8]) : i_cfg_current);
  endproperty
  a_cur: assert property (p_cur) else $error("current pick");
  property p_lock;
    o_locked |=> o_locked && !o_cmd_valid;
  endproperty
  a_lock: assert property (p_lock) else $error("lock broken");
endmodule

/* dv/tb.sv */
/* Top bench: controller and device ends joined by the link, random blocks,
   then encoder store and flash lockout. Assumes the design files precede. */
`timescale 1ns/1ns
`include "mcb_regs.svh"
module tb;
  logic i_ref_clk = 0, i_arst_n = 0, i_wr = 0, fd = 0, fok = 0, eo = 0, bs = 0, ss = 0;
  logic [3:0] i_idx = 0;
  logic [15:0] i_data = 0, cfg = 16'h0012, st, cur, acc, dec, jrk;
  logic [15:0] w [10], ew [10];
  logic v, ccw, grn, lk, cv, rerr, sst, est, red, hld, srp, ecw = 0, er = 0, eh = 0;
  logic [31:0] tgt, et, spd;
  mcb_pkg::mcb_op_e op;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  mcb_if bus ();
  mcb_ctrl mcb_ctrl_inst (.i_ref_clk, .i_arst_n, .i_wr, .i_idx, .i_data, .o_status1(st),
    .bus(bus));
  mcb_dev mcb_dev_inst (.i_ref_clk, .i_arst_n, .i_cfg_current(cfg), .i_flash_done(fd),
    .i_flash_ok(fok), .i_enc_store_ok(eo), .i_blend_start(bs), .i_at_start_speed(ss),
    .o_cmd_valid(v), .o_op(op), .o_target(tgt), .o_speed(spd), .o_accel(acc), .o_decel(dec),
    .o_jerk(jrk), .o_current(cur), .o_cur_valid(cv), .o_range_err(rerr), .o_blend_ccw(ccw),
    .o_seg_store(sst), .o_enc_store(est), .o_led_green(grn), .o_led_red(red), .o_locked(lk),
    .o_held(hld), .o_stop_ramp(srp), .bus(bus));
  mcb_monitor mcb_monitor_inst (.i_ref_clk, .i_arst_n, .words(bus.words),
    .i_cfg_current(cfg), .o_cmd_valid(v), .o_op(op), .o_target(tgt), .o_current(cur),
    .o_locked(lk));
  always #5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] k, input logic [15:0] d);
    i_wr = 1;
    i_idx = k;
    i_data = d;
    @(posedge i_ref_clk);
    #1;
  endtask
  task idle(input int n);
    i_wr = 0;
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  function automatic mcb_pkg::mcb_op_e exp_op(input logic [15:0] c);
    case (c)
      16'h0001: return mcb_pkg::MCB_OP_ABS;
      16'h0002: return mcb_pkg::MCB_OP_REL;
      16'h0004: return mcb_pkg::MCB_OP_HOLD;
      16'h0008: return mcb_pkg::MCB_OP_RESUME;
      default: return mcb_pkg::MCB_OP_ESTOP;
    endcase
  endfunction
  function automatic logic [15:0] exp_cur(input logic [15:0] c1, input logic [15:0] w8);
    return (c1[1] && w8 <= 16'h0022) ? w8 : cfg;
  endfunction
  initial begin
    logic [15:0] code;
    logic [31:0] t;
    void'($urandom(32'h383BC996));
    repeat (6) @(posedge i_ref_clk);
    #1;
    i_arst_n = 1;
    // first five pass every code once, first two at the range ends
    for (int i = 0; i < 60; i++) begin
      code = 16'h0001 << (i < 5 ? i : $urandom_range(4));
      t = $urandom;
      t = i < 2 ? (i ? 32'h007FFFFF : 32'hFF800000) : {{8{t[23]}}, t[23:0]};
      w[1] = $urandom;
      {w[2], w[3]} = t;
      {w[4], w[5]} = $urandom_range(2999999, 1);
      w[6] = $urandom_range(5000, 1);
      // corner: decel one past its range on the first resume
      w[7] = i == 3 ? 16'h1389 : 16'($urandom_range(5000, 1));
      w[8] = $urandom_range(40);
      w[9] = $urandom_range(5000);
      wr(0, 16'h0000);
      for (int k = 1; k < 10; k++) wr(k[3:0], w[k]);
      wr(0, code);
      bs = 1'($urandom_range(1));
      idle(1);
      if (code < 4) et = t;
      if (code < 4 || code == 8) begin
        ew = w;
        er = {w[4], w[5]} > `MCB_SPD_MAX || w[6] < `MCB_RAMP_MIN || w[6] > `MCB_RAMP_MAX
          || w[7] < `MCB_RAMP_MIN || w[7] > `MCB_RAMP_MAX || w[9] > `MCB_RAMP_MAX;
      end
      if (code != 4) eh = 0;
      if (bs) ecw = w[1][4];
      chk(v, 1);
      chk(op, exp_op(code));
      chk(tgt, et);
      chk(spd, {ew[4], ew[5]});
      chk(acc, ew[6]);
      chk(dec, ew[7]);
      chk(jrk, ew[9]);
      chk(rerr, er);
      chk(ccw, ecw);
      chk(bus.words[1] & 16'h000D, 0);
      if (code < 4 || code == 8) chk(cur, exp_cur(w[1], w[8]));
      chk(cv, code < 4 || code == 8);
      chk(srp, code == 4);
      chk(hld, eh);
      bs = 0;
      idle(1);
      chk(v, 0);
      if (code == 4) begin
        ss = 1;
        idle(1);
        ss = 0;
        eh = 1;
        chk(srp, 0);
        chk(hld, 1);
      end
    end
    // standalone current update, then one step past the top of range
    wr(1, 16'h0002);
    wr(8, 16'h0021);
    wr(8, 16'h0022);
    idle(1);
    chk(cur, 16'h0022);
    chk(cv, 1);
    wr(8, 16'h0023);
    idle(1);
    chk(cur, cfg);
    wr(1, 16'h0020);
    wr(0, 16'h4000);
    idle(1);
    chk(est, 1);
    eo = 1;
    idle(1);
    eo = 0;
    idle(2);
    chk(st[13], 1);
    wr(0, 16'h1000);
    wr(0, 16'h0000);
    idle(1);
    chk(sst, 1);
    fok = 1;
    fd = 1;
    idle(1);
    fd = 0;
    idle(1);
    chk(grn, 1);
    chk(red, 0);
    chk(lk, 1);
    wr(0, 16'h0001);
    idle(2);
    chk(v, 0);
    tally_and_finish();
  end
endmodule
